// [design/hib_ifc_pkg.sv]
// Constants and field layouts for the hibernate and
// interface-control register pair.
// Assumes register indices arrive on an 8-bit index port.
package hib_ifc_pkg;

    // Register indices on the control interface
    localparam logic [7:0]  SLEEP_CTRL_ADDR = 8'h05;
    localparam logic [7:0]  LINK_CTRL_ADDR  = 8'h06;

    // Reset values
    localparam logic [15:0] SLEEP_RESET     = 16'h0000;
    localparam logic [15:0] LINK_RESET      = 16'h8A00;

    // Writable bits; key-protected bits kept apart
    localparam logic [15:0] SLEEP_WR_MASK   = 16'h80FF;
    localparam logic [15:0] LINK_OPEN_MASK  = 16'hFA00;
    localparam logic [15:0] LINK_KEY_MASK   = 16'h000E;
    // Bits restored by the power state machine
    localparam logic [15:0] LINK_SM_MASK    = 16'hF200;

    // Boot configuration code that enables the pin select, bus address and done fields
    localparam logic [1:0]  BOOT_HOST_CFG   = 2'h0;

    // Two-wire bus address per select code
    localparam logic [6:0]  BUS_ADDR_0      = 7'h34;
    localparam logic [6:0]  BUS_ADDR_1      = 7'h36;
    localparam logic [6:0]  BUS_ADDR_2      = 7'h3C;
    localparam logic [6:0]  BUS_ADDR_3      = 7'h3E;

    // Watchdog action codes
    typedef enum logic [1:0] {
        WDOG_OFF       = 2'b00,
        WDOG_IRQ       = 2'b01,
        WDOG_IRQ_RST   = 2'b10,
        WDOG_TWO_STAGE = 2'b11
    } wdog_action_type;

    // Hibernate register layout, bit 15 down to 0
    typedef struct packed {
        logic       hibernate;
        logic [6:0] rsvd;
        logic       watchdog_sleep_sel;
        logic       wake_via_startup;
        logic       wake_register_clear;
        logic       sleep_sysreset_level;
        logic       sleep_interrupt_suppress;
        logic       sleep_memory_reset_level;
        logic       sleep_hyst_comparator_on;
        logic       sleep_thermal_watch_on;
    } sleep_cfg_type;

    // Interface-control register layout, bit 15 down to 0
    typedef struct packed {
        logic       alt_twowire_pin_sel;
        logic [1:0] bus_address_sel;
        logic       config_done;
        logic       reload_on_power_on;
        logic       rsvd_10;
        logic       addr_step_enable;
        logic [4:0] rsvd_8_4;
        logic       serial_out_open_drain;
        logic       four_wire_sel;
        logic       three_four_wire_sel;
        logic       rsvd_0;
    } link_cfg_type;

endpackage

// [design/hib_ifc_regs.sv]
// Hibernate and interface-control register pair with the
// pin and function gating that those bits steer.
// Assumes a host port of synchronous index/strobe signals
// and a power state machine that issues restore pulses.
`timescale 1ns/100ps

module hib_ifc_regs
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Host register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        key_unlocked,
    // Power state machine side
    input  wire logic        sm_restore,
    input  wire logic        power_on_event,
    input  wire logic        dev_mode,
    input  wire logic [1:0]  boot_config_status,
    output logic             hibernating,
    output logic             wake_direct_pulse,
    output logic             wake_startup_pulse,
    output logic             wake_register_clear_pulse,
    output logic             off_register_reset_en,
    output logic             load_config_pulse,
    // Watchdog gating
    input  wire logic [1:0]  watchdog_action_sel,
    output logic             watchdog_irq_en,
    output logic             watchdog_reset_first,
    output logic             watchdog_reset_second,
    // Pins and functions gated in hibernate
    input  wire logic        sysreset_req_n,
    output logic             sysreset_n,
    input  wire logic        irq_req_n,
    output logic             irq_n,
    input  wire logic        memory_reset_req_n,
    output logic             memory_reset_pin_n,
    input  wire logic        hyst_comparator_req,
    output logic             hyst_comparator_en,
    input  wire logic        thermal_watch_req,
    output logic             thermal_watch_en,
    // Control interface configuration
    output logic             alt_twowire_pins,
    output logic      [6:0]  bus_address,
    output logic             config_done,
    output logic             addr_step_enable,
    output logic             serial_data_bidir,
    input  wire logic        serial_out_data,
    output logic             serial_out_pin_o,
    output logic             serial_out_pin_oe
);

    hib_ifc_pkg::sleep_cfg_type sleep_r;
    hib_ifc_pkg::sleep_cfg_type sleep_nxt;
    hib_ifc_pkg::link_cfg_type  link_r;
    hib_ifc_pkg::link_cfg_type  link_nxt;
    logic                       first_power_r;
    logic [15:0]                link_mask;
    logic                       wr_sleep;
    logic                       wr_link;
    logic                       leaving;
    logic                       boot_host;
    logic                       four_wire_on;
    logic [1:0]                 wdog_eff;

    // Address decode
    assign wr_sleep = reg_wr && (reg_addr == hib_ifc_pkg::SLEEP_CTRL_ADDR);
    assign wr_link  = reg_wr && (reg_addr == hib_ifc_pkg::LINK_CTRL_ADDR);

    assign link_mask = key_unlocked
        ? (hib_ifc_pkg::LINK_OPEN_MASK | hib_ifc_pkg::LINK_KEY_MASK)
        : hib_ifc_pkg::LINK_OPEN_MASK;

    // Next hibernate register; host write beats the restore
    always_comb
    begin
        sleep_nxt = sleep_r;
        if (sm_restore)
        begin
            sleep_nxt.hibernate = 1'b0;
        end
        if (wr_sleep)
        begin
            sleep_nxt = hib_ifc_pkg::sleep_cfg_type'(
                (sleep_r & ~hib_ifc_pkg::SLEEP_WR_MASK)
                | (reg_wdata & hib_ifc_pkg::SLEEP_WR_MASK));
        end
    end

    // Next link register; host write beats the restore
    always_comb
    begin
        link_nxt = link_r;
        if (sm_restore)
        begin
            link_nxt = hib_ifc_pkg::link_cfg_type'(
                (link_r & ~hib_ifc_pkg::LINK_SM_MASK)
                | (hib_ifc_pkg::LINK_RESET & hib_ifc_pkg::LINK_SM_MASK));
        end
        if (wr_link)
        begin
            link_nxt = hib_ifc_pkg::link_cfg_type'(
                (link_r & ~link_mask) | (reg_wdata & link_mask));
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleep_r <= hib_ifc_pkg::sleep_cfg_type'(hib_ifc_pkg::SLEEP_RESET);
        end
        else
        begin
            sleep_r <= sleep_nxt;
        end
    end

    // link register storage, defaults from reset
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_r <= hib_ifc_pkg::link_cfg_type'(hib_ifc_pkg::LINK_RESET);
        end
        else
        begin
            link_r <= link_nxt;
        end
    end

    // Read data; unmapped index and reserved bits read zero
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                hib_ifc_pkg::SLEEP_CTRL_ADDR: reg_rdata <= sleep_r;
                hib_ifc_pkg::LINK_CTRL_ADDR:  reg_rdata <= link_r;
                default:                      reg_rdata <= 16'h0000;
            endcase
        end
    end

    // Wake requests fire with the fall of the hibernate bit
    assign leaving = sleep_r.hibernate && !sleep_nxt.hibernate;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_direct_pulse         <= 1'b0;
            wake_startup_pulse        <= 1'b0;
            wake_register_clear_pulse <= 1'b0;
        end
        else
        begin
            wake_direct_pulse  <= leaving && !sleep_r.wake_via_startup;
            wake_startup_pulse <= leaving && sleep_r.wake_via_startup;
            wake_register_clear_pulse <= leaving && sleep_r.wake_register_clear;
        end
    end

    // first power-up tracker, cleared by first event
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            first_power_r <= 1'b1;
        end
        else if (power_on_event)
        begin
            first_power_r <= 1'b0;
        end
    end

    // reload on power-on; dev mode forces first load
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_config_pulse <= 1'b0;
        end
        else
        begin
            load_config_pulse <= power_on_event
                && (link_r.reload_on_power_on || (dev_mode && first_power_r));
        end
    end

    // register reset in the off state
    assign off_register_reset_en = link_r.reload_on_power_on;
    assign hibernating           = sleep_r.hibernate;

    // watchdog gated off in hibernate unless kept
    assign wdog_eff = (sleep_r.hibernate && !sleep_r.watchdog_sleep_sel)
        ? hib_ifc_pkg::WDOG_OFF : watchdog_action_sel;

    assign watchdog_irq_en       = (wdog_eff != hib_ifc_pkg::WDOG_OFF);
    assign watchdog_reset_first  = (wdog_eff == hib_ifc_pkg::WDOG_IRQ_RST);
    assign watchdog_reset_second = (wdog_eff == hib_ifc_pkg::WDOG_TWO_STAGE);

    // pin gating only while hibernating; pass-through
    // keeps normal reset and interrupt paths free of latency
    // system reset level
    assign sysreset_n = sleep_r.hibernate ? sleep_r.sleep_sysreset_level : sysreset_req_n;
    assign irq_n = (sleep_r.hibernate && sleep_r.sleep_interrupt_suppress) ? 1'b1 : irq_req_n;
    assign memory_reset_pin_n = sleep_r.hibernate ? sleep_r.sleep_memory_reset_level : memory_reset_req_n;
    assign hyst_comparator_en = sleep_r.hibernate ? sleep_r.sleep_hyst_comparator_on : hyst_comparator_req;
    assign thermal_watch_en = sleep_r.hibernate ? sleep_r.sleep_thermal_watch_on : thermal_watch_req;

    // Pin select, bus address and done fields apply only with host boot configuration
    assign boot_host = (boot_config_status == hib_ifc_pkg::BOOT_HOST_CFG);

    assign alt_twowire_pins = boot_host && link_r.alt_twowire_pin_sel;

    // address map; other boot modes use code 00
    always_comb
    begin
        case (boot_host ? link_r.bus_address_sel : 2'b00)
            2'b00:   bus_address = hib_ifc_pkg::BUS_ADDR_0;
            2'b01:   bus_address = hib_ifc_pkg::BUS_ADDR_1;
            2'b10:   bus_address = hib_ifc_pkg::BUS_ADDR_2;
            2'b11:   bus_address = hib_ifc_pkg::BUS_ADDR_3;
            default: bus_address = hib_ifc_pkg::BUS_ADDR_0;
        endcase
    end

    // loader completion flag, boot 00 only
    assign config_done = boot_host && link_r.config_done;
    assign addr_step_enable = link_r.addr_step_enable;

    assign four_wire_on = link_r.three_four_wire_sel && link_r.four_wire_sel;
    assign serial_data_bidir = link_r.three_four_wire_sel && !link_r.four_wire_sel;

    // serial out drive; open drain only pulls low
    assign serial_out_pin_o  = link_r.serial_out_open_drain ? 1'b0 : serial_out_data;
    assign serial_out_pin_oe = four_wire_on
        && (!link_r.serial_out_open_drain || !serial_out_data);

    // Checks
    hib_clear_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        sm_restore && !wr_sleep |=> !sleep_r.hibernate)
        else $error("hibernate bit not cleared by restore");
    wdog_gate_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        sleep_r.hibernate && !sleep_r.watchdog_sleep_sel |-> !watchdog_irq_en
            && !watchdog_reset_first && !watchdog_reset_second)
        else $error("watchdog active in hibernate");
    wake_path_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        $fell(sleep_r.hibernate) |-> (wake_startup_pulse == $past(sleep_r.wake_via_startup))
            && (wake_direct_pulse != wake_startup_pulse))
        else $error("wrong wake path");
    wake_clear_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        wake_register_clear_pulse |-> $fell(sleep_r.hibernate)
            && $past(sleep_r.wake_register_clear))
        else $error("register clear without wake");
    sysreset_level_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        sleep_r.hibernate |-> sysreset_n == sleep_r.sleep_sysreset_level)
        else $error("system reset level wrong");
    irq_force_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        !sleep_r.hibernate || !sleep_r.sleep_interrupt_suppress
            |-> irq_n == irq_req_n)
        else $error("interrupt gated outside suppression");
    irq_quiet_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        sleep_r.hibernate && sleep_r.sleep_interrupt_suppress |-> irq_n)
        else $error("interrupt not suppressed in hibernate");
    memory_reset_pin_level_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        sleep_r.hibernate |-> memory_reset_pin_n == sleep_r.sleep_memory_reset_level)
        else $error("memory reset level wrong");
    thermal_gate_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        sleep_r.hibernate && !sleep_r.sleep_thermal_watch_on |-> !thermal_watch_en)
        else $error("thermal watch on in hibernate");
    addr_map_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        boot_host && link_r.bus_address_sel == 2'b10 |-> bus_address == 7'h3C)
        else $error("bus address map wrong");

    key_guard_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        !key_unlocked |=> $stable(link_r.serial_out_open_drain))
        else $error("drive type changed while locked");

    step_restore_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        sm_restore && !wr_link |=> link_r.addr_step_enable && link_r.alt_twowire_pin_sel)
        else $error("restore missed link defaults");

endmodule

// [tb/host_model.sv]
// Host model: drives the register port and the security key.
// Assumes the bench owns the clock and calls these tasks in turn.
`timescale 1ns/100ps

module host_model
(
    input  wire logic        clock,
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    output logic             key_unlocked
);
    // Idle bus at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        key_unlocked = 1'b0;
    end

    // One strobe held over one rising edge; released lines change pattern
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(negedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(negedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic set_key(input logic k);
        @(negedge clock);
        key_unlocked <= k;
    endtask

    // loader marks done, reload bit kept at 1
    task automatic loader_done(input logic [1:0] code);
        xfer(1'b1, 8'h06, {1'b1, code, 1'b1, 1'b1, 11'h200});
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the hibernate and link control registers.
// Assumes host_model on the register port; bench drives the rest.
`timescale 1ns/100ps

module testbench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sm_restore = 1'b0;
    logic power_on_event = 1'b0;
    logic dev_mode = 1'b0;
    logic [1:0] boot_config_status = 2'b00;
    logic [7:0] req_v = 8'hFF;
    logic [7:0] reg_addr;
    logic reg_wr, reg_rd, key_unlocked, rd_d = 1'b0;
    logic [15:0] reg_wdata, reg_rdata, v;
    logic hibernating, wake_direct_pulse, wake_startup_pulse, wake_register_clear_pulse;
    logic off_register_reset_en, load_config_pulse, watchdog_irq_en, watchdog_reset_first;
    logic watchdog_reset_second, sysreset_n, irq_n, memory_reset_pin_n, hyst_comparator_en;
    logic thermal_watch_en, alt_twowire_pins, config_done, addr_step_enable;
    logic serial_data_bidir, serial_out_pin_o, serial_out_pin_oe, h;
    logic [6:0] bus_address;
    logic [1:0] eff;
    logic [15:0] exp_q[$];
    logic [6:0] addr_tab[4] = '{7'h34, 7'h36, 7'h3C, 7'h3E};
    int n_fail = 0;
    int total_checks = 0;
    wire logic [1:0] watchdog_action_sel = req_v[7:6];

    always #50 clock = ~clock;

    host_model i_host (.clock, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .key_unlocked);

    hib_ifc_regs i_dut (.clock, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .key_unlocked, .sm_restore, .power_on_event, .dev_mode, .boot_config_status, .hibernating,
        .wake_direct_pulse, .wake_startup_pulse, .wake_register_clear_pulse, .off_register_reset_en,
        .load_config_pulse, .watchdog_action_sel, .watchdog_irq_en, .watchdog_reset_first,
        .watchdog_reset_second, .sysreset_req_n(req_v[5]), .sysreset_n, .irq_req_n(req_v[4]), .irq_n,
        .memory_reset_req_n(req_v[3]), .memory_reset_pin_n, .hyst_comparator_req(req_v[2]),
        .hyst_comparator_en, .thermal_watch_req(req_v[1]), .thermal_watch_en, .alt_twowire_pins,
        .bus_address, .config_done, .addr_step_enable, .serial_data_bidir,
        .serial_out_data(req_v[0]), .serial_out_pin_o, .serial_out_pin_oe);

    task automatic chk_read(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected read data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [6:0] got, input logic [6:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected output at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Read answer is registered on the strobe edge and checked half a cycle later; no valid flag
    always @(posedge clock) rd_d <= reg_rd;
    always @(negedge clock)
    begin
        if (rd_d)
        begin
            if (exp_q.size() == 0)
                chk_read(reg_rdata, 16'hxxxx);
            else
                chk_read(reg_rdata, exp_q.pop_front());
        end
    end

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        i_host.xfer(1'b0, a, 16'h0000);
    endtask

    // One-cycle pulse on an event input, then look at the reload pulse
    task automatic pon(input logic e);
        @(negedge clock);
        power_on_event = 1'b1;
        @(negedge clock);
        power_on_event = 1'b0;
        chk_pin(load_config_pulse, e);
    endtask

    task automatic do_reset;
        rst_n = 1'b0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
    endtask

    // Hang guard: a run this long counts as a mismatch
    initial
    begin
        #(20000 * 100);
        n_fail++;
        close_out();
    end

    initial
    begin
        void'($urandom(32'h7c80));
        do_reset();
        i_host.xfer(1'b1, 8'h07, 16'hFFFF);
        rd(8'h05, 16'h0000);
        rd(8'h06, 16'h8A00);
        rd(8'h07, 16'h0000);
        chk_pin(bus_address, 7'h34);
        // Random hibernate settings against random normal requests
        repeat (14)
        begin
            v = 16'($urandom);
            i_host.xfer(1'b1, 8'h05, v);
            req_v = 8'($urandom);
            #1;
            h = v[15];
            eff = (h && !v[7]) ? 2'b00 : req_v[7:6];
            chk_pin(hibernating, h);
            chk_pin(sysreset_n, h ? v[4] : req_v[5]);
            chk_pin(irq_n, (h && v[3]) ? 1'b1 : req_v[4]);
            chk_pin(memory_reset_pin_n, h ? v[2] : req_v[3]);
            chk_pin(hyst_comparator_en, h ? v[1] : req_v[2]);
            chk_pin(thermal_watch_en, h ? v[0] : req_v[1]);
            chk_pin(watchdog_irq_en, eff != 2'b00);
            chk_pin(watchdog_reset_first, eff == 2'b10);
            chk_pin(watchdog_reset_second, eff == 2'b11);
            rd(8'h05, v & 16'h80FF);
        end
        // Leaving hibernate by host write, then by the state machine
        i_host.xfer(1'b1, 8'h05, 16'h8060);
        i_host.xfer(1'b1, 8'h05, 16'h0060);
        chk_pin({wake_startup_pulse, wake_register_clear_pulse, wake_direct_pulse}, 7'h6);
        @(negedge clock);
        chk_pin({wake_startup_pulse, wake_register_clear_pulse}, 7'h0);
        i_host.xfer(1'b1, 8'h05, 16'h8000);
        @(negedge clock);
        sm_restore = 1'b1;
        @(negedge clock);
        sm_restore = 1'b0;
        chk_pin({hibernating, wake_direct_pulse, wake_startup_pulse}, 7'h2);
        // Key-protected bits refused while locked
        i_host.set_key(1'b0);
        i_host.xfer(1'b1, 8'h06, 16'hFFFF);
        rd(8'h06, 16'hFA00);
        i_host.set_key(1'b1);
        i_host.xfer(1'b1, 8'h06, 16'hFFFF);
        rd(8'h06, 16'hFA0E);
        for (int m = 0; m < 3; m++)
        begin
            i_host.xfer(1'b1, 8'h06, m == 0 ? 16'h000E : (m == 1 ? 16'h0006 : 16'h0002));
            for (int d = 0; d < 2; d++)
            begin
                @(negedge clock);
                req_v[0] = d[0];
                #1;
                if (m == 0)
                    chk_pin({serial_out_pin_oe, serial_out_pin_o}, {!d[0], 1'b0});
                else if (m == 1)
                    chk_pin({serial_out_pin_oe, serial_out_pin_o}, {1'b1, d[0]});
                else
                    chk_pin({serial_out_pin_oe, serial_data_bidir}, 7'h1);
            end
        end
        // Address codes against every boot status
        for (int c = 0; c < 4; c++)
        begin
            i_host.loader_done(c[1:0]);
            for (int b = 0; b < 4; b++)
            begin
                @(negedge clock);
                boot_config_status = b[1:0];
                #1;
                chk_pin(bus_address, b == 0 ? addr_tab[c] : 7'h34);
                chk_pin({alt_twowire_pins, config_done}, b == 0 ? 7'h3 : 7'h0);
                chk_pin({addr_step_enable, off_register_reset_en}, 7'h3);
            end
            boot_config_status = 2'b00;
        end
        i_host.xfer(1'b1, 8'h06, 16'h7002);
        chk_pin({addr_step_enable, off_register_reset_en, alt_twowire_pins}, 7'h0);
        pon(1'b0);
        @(negedge clock);
        sm_restore = 1'b1;
        @(negedge clock);
        sm_restore = 1'b0;
        rd(8'h06, 16'h8202);
        i_host.xfer(1'b1, 8'h06, 16'h0800);
        pon(1'b1);
        // Development mode loads once after reset despite a clear reload bit
        do_reset();
        dev_mode = 1'b1;
        i_host.xfer(1'b1, 8'h06, 16'h8200);
        pon(1'b1);
        pon(1'b0);
        repeat (3) @(negedge clock);
        close_out();
    end
endmodule
